// ### design/dlss_pkg.sv
package dlss_pkg;

  localparam int unsigned MCLK_HZ          = 20000000;
  localparam int unsigned MS_PER_TICK      = 1;
  localparam int unsigned TICK_CYCLES      = MCLK_HZ / 1000 * MS_PER_TICK;
  localparam int unsigned PULSE_MIN_MS     = 32;
  localparam int unsigned TICK_W           = 15;
  localparam int unsigned MS_W             = 6;

  localparam logic [9:0] SRC_LOGIC3        = 10'd224;
  localparam logic [9:0] SRC_LOGIC3_INV    = 10'd225;
  localparam logic [9:0] SRC_LOGIC4        = 10'd226;
  localparam logic [9:0] SRC_LOGIC4_INV    = 10'd227;
  localparam logic [9:0] SRC_BASE_LO       = 10'd70;
  localparam logic [9:0] SRC_BASE_HI       = 10'd76;
  localparam logic [9:0] SRC_INV_LO        = 10'd270;
  localparam logic [9:0] SRC_INV_HI        = 10'd276;
  localparam logic [9:0] SRC_POS_REACHED   = 10'd282;
  localparam logic [9:0] SRC_EXP_LO        = 10'd320;
  localparam logic [9:0] SRC_EXP_HI        = 10'd322;
  localparam logic [9:0] SRC_EXP_INV_LO    = 10'd520;
  localparam logic [9:0] SRC_EXP_INV_HI    = 10'd522;
  localparam logic [9:0] SRC_HW_LO         = 10'd525;
  localparam logic [9:0] SRC_HW_HI         = 10'd530;
  localparam logic [9:0] SRC_MFI           = 10'd531;
  localparam logic [9:0] SRC_EXPHW_LO      = 10'd532;
  localparam logic [9:0] SRC_EXPHW_HI      = 10'd534;
  localparam logic [9:0] SRC_HWINV_LO      = 10'd537;
  localparam logic [9:0] SRC_HWINV_HI      = 10'd545;
  localparam logic [9:0] SRC_PDO1_LO       = 10'd700;
  localparam logic [9:0] SRC_PDO1_HI       = 10'd703;
  localparam logic [9:0] SRC_PDO2_LO       = 10'd710;
  localparam logic [9:0] SRC_PDO2_HI       = 10'd713;
  localparam logic [9:0] SRC_PDO3_LO       = 10'd720;
  localparam logic [9:0] SRC_PDO3_HI       = 10'd723;
  localparam logic [9:0] SRC_EMERGENCY     = 10'd730;

  localparam logic [2:0] MFI_MODE_DIGITAL  = 3'd3;
  localparam logic [5:0] LOC_3WIRE         = 6'd5;
  localparam logic [5:0] LOC_3WIRE_KP      = 6'd46;

  // Raw external levels, unsynchronised.
  typedef struct packed {
    logic [5:0] board;
    logic       mfi;
    logic [2:0] expansion;
  } dlss_pins_t;

  // Internal boolean signals on the system clock.
  typedef struct packed {
    logic [6:0]  base;
    logic        logic3;
    logic        logic4;
    logic        posReached;
    logic [2:0]  expRemote;
    logic [2:0]  expRemoteSel;
    logic [3:0]  pdo1;
    logic [3:0]  pdo2;
    logic [3:0]  pdo3;
    logic        emergency;
    logic        sysbusFitted;
  } dlss_internal_t;

  // Source selection codes for each consumer function.
  typedef struct packed {
    logic [9:0] startCw;
    logic [9:0] startAcw;
    logic [9:0] threeWire;
    logic [9:0] errAck;
    logic [9:0] timer1;
    logic [9:0] timer2;
    logic [9:0] thermo;
  } dlss_sel_t;

endpackage

// ### design/dlss_source_mux.sv
`timescale 1ns/1ps
`default_nettype none

module dlss_source_mux (
  // Selection code
  input  wire logic [9:0]             code,
  // Candidate signals
  input  wire logic [5:0]             board,
  input  wire logic                   mfiDigital,
  input  wire logic [2:0]             expHw,
  input  wire logic [2:0]             expEff,
  input  wire dlss_pkg::dlss_internal_t intl,
  // Selected level
  output logic                        value
);

  logic [8:0] hwVec;
  int         idx;

  assign hwVec = {expHw[1:0], mfiDigital, board};

  always_comb begin
    value = 1'b0;
    idx = 0;
    if (code >= dlss_pkg::SRC_BASE_LO && code <= dlss_pkg::SRC_BASE_HI) begin
      idx = int'(code - dlss_pkg::SRC_BASE_LO);
      value = intl.base[idx];
    end else if (code >= dlss_pkg::SRC_INV_LO && code <= dlss_pkg::SRC_INV_HI) begin
      idx = int'(code - dlss_pkg::SRC_INV_LO);
      value = ~intl.base[idx]; // [R03]
    end else if (code == dlss_pkg::SRC_LOGIC3) begin
      value = intl.logic3; // [R01]
    end else if (code == dlss_pkg::SRC_LOGIC3_INV) begin
      value = ~intl.logic3; // [R01]
    end else if (code == dlss_pkg::SRC_LOGIC4) begin
      value = intl.logic4; // [R02]
    end else if (code == dlss_pkg::SRC_LOGIC4_INV) begin
      value = ~intl.logic4; // [R02]
    end else if (code == dlss_pkg::SRC_POS_REACHED) begin
      value = intl.posReached; // [R04]
    end else if (code >= dlss_pkg::SRC_EXP_LO && code <= dlss_pkg::SRC_EXP_HI) begin
      idx = int'(code - dlss_pkg::SRC_EXP_LO);
      value = expEff[idx]; // [R05]
    end else if (code >= dlss_pkg::SRC_EXP_INV_LO && code <= dlss_pkg::SRC_EXP_INV_HI) begin
      idx = int'(code - dlss_pkg::SRC_EXP_INV_LO);
      value = ~expEff[idx]; // [R05]
    end else if (code >= dlss_pkg::SRC_HW_LO && code <= dlss_pkg::SRC_EXPHW_HI) begin
      idx = int'(code - dlss_pkg::SRC_HW_LO);
      if (idx < 9) begin
        value = hwVec[idx]; // [R06] [R07] [R08]
      end else begin
        value = expHw[2]; // [R08]
      end
    end else if (code >= dlss_pkg::SRC_HWINV_LO && code <= dlss_pkg::SRC_HWINV_HI) begin
      idx = int'(code - dlss_pkg::SRC_HWINV_LO);
      value = ~hwVec[idx]; // [R09]
    end else if (code >= dlss_pkg::SRC_PDO1_LO && code <= dlss_pkg::SRC_PDO1_HI) begin
      idx = int'(code - dlss_pkg::SRC_PDO1_LO);
      value = intl.sysbusFitted & intl.pdo1[idx]; // [R10]
    end else if (code >= dlss_pkg::SRC_PDO2_LO && code <= dlss_pkg::SRC_PDO2_HI) begin
      idx = int'(code - dlss_pkg::SRC_PDO2_LO);
      value = intl.sysbusFitted & intl.pdo2[idx]; // [R11]
    end else if (code >= dlss_pkg::SRC_PDO3_LO && code <= dlss_pkg::SRC_PDO3_HI) begin
      idx = int'(code - dlss_pkg::SRC_PDO3_LO);
      value = intl.sysbusFitted & intl.pdo3[idx]; // [R11]
    end else if (code == dlss_pkg::SRC_EMERGENCY) begin
      value = intl.sysbusFitted & intl.emergency; // [R12]
    end
  end

endmodule

`default_nettype wire

// ### design/dlss_top.sv
// Summary of operation
// [R01] Code 224 gives logic module three output, 225 its complement.
// [R02] Code 226 gives logic module four output, 227 its complement.
// [R03] Codes 270..276 give inverted codes 70..76.
// [R04] Code 282 is high while positioning reports reference orientation reached.
// [R05] Codes 320..322 give expansion inputs or remote values; 520..522 complements.
// [R06] Codes 525..530 give the six board inputs, independent of control location.
// [R07] Code 531 gives the multifunction input only when its mode is digital.
// [R08] Codes 532..534 give raw expansion input levels without remote override.
// [R09] Codes 537..545 give inverted codes 525..533.
// [R10] Codes 700..703 give first received object booleans when system bus fitted.
// [R11] Codes 710..713 and 720..723 give second and third object booleans.
// [R12] Code 730 gives the system-bus emergency indication.
// [R13] Clockwise and anticlockwise start each take a selectable source; no start, no run.
// [R14] Three-wire start needs enable on and a rising edge on a start source.
// [R15] Enable on latches the start; enable off clears it and stops the drive.
// [R16] Once latched, further start edges are ignored until release.
// [R17] A start pulse shorter than 32 ms stops the drive.
// [R18] Both start sources active within 32 ms of each other stops the drive.
// [R19] Three-wire works only with control location 5 or 46.
// [R20] Fault is cleared by the programming command or the acknowledge source.
// [R21] Each timer takes its trigger from a selectable source and its own mode.
// [R22] Thermo contact takes a selectable source and passes its level on.
// [R23] External sources are synchronised; pulse timing uses a millisecond tick.
`timescale 1ns/1ps
`default_nettype none

module dlss_top (
  // Clock and reset
  input  wire logic                     mclk,
  input  wire logic                     nrst,
  // External pins
  input  wire dlss_pkg::dlss_pins_t     pins,
  // Internal signals and configuration
  input  wire dlss_pkg::dlss_internal_t intl,
  input  wire dlss_pkg::dlss_sel_t      sel,
  input  wire logic [2:0]               mfiMode,
  input  wire logic [5:0]               localRemote,
  input  wire logic                     progAck,
  input  wire logic                     faultEvent,
  input  wire logic [3:0]               timer1Mode,
  input  wire logic [3:0]               timer2Mode,
  // Drive command
  output logic                          runCw,
  output logic                          runAcw,
  output logic                          stopReq,
  // Fault and function inputs
  output logic                          faultActive,
  output logic                          errAckPulse,
  output logic                          timer1Trig,
  output logic                          timer2Trig,
  output logic [3:0]                    timer1ModeOut,
  output logic [3:0]                    timer2ModeOut,
  output logic                          thermoLevel
);

  localparam int NSRC = 7;

  logic [9:0]  sync1_q;
  logic [9:0]  sync2_q;
  logic [5:0]  board;
  logic        mfiDigital;
  logic [2:0]  expHw;
  logic [2:0]  expEff;
  logic [9:0]  codes [NSRC];
  logic [NSRC-1:0] srcVal;
  logic [NSRC-1:0] src_q;
  logic        cwNow;
  logic        acwNow;
  logic        enNow;
  logic        cwRise;
  logic        acwRise;
  logic        threeWireMode;
  logic        enEff;
  logic [dlss_pkg::TICK_W-1:0] tick_q;
  logic        msTick;
  logic        latched_q;
  logic        dirCw_q;
  logic        checking_q;
  logic [dlss_pkg::MS_W-1:0] ms_q;
  logic        run_d;
  // Three-wire control and edge qualifiers.
  logic [2:0]  arm_q;
  logic        edgeArm;
  logic        bothRise;
  logic        startNow;
  logic        pulseBad;
  logic        abortNow;
  logic        stopNow;
  logic        windowEnd;
  logic        ackRise;

  // Two-stage synchronisers on every pin.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      sync1_q <= 10'h000;
      sync2_q <= 10'h000;
    end else begin
      sync1_q <= pins; // [R23]
      sync2_q <= sync1_q; // [R23]
    end
  end

  assign board = sync2_q[9:4];
  assign mfiDigital = sync2_q[3] & (mfiMode == dlss_pkg::MFI_MODE_DIGITAL); // [R07]
  assign expHw = sync2_q[2:0];

  // Remote override applies only to the non-hardware expansion codes.
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      expEff[i] = intl.expRemoteSel[i] ? intl.expRemote[i] : expHw[i]; // [R05]
    end
  end

  assign codes[0] = sel.startCw;
  assign codes[1] = sel.startAcw;
  assign codes[2] = sel.threeWire;
  assign codes[3] = sel.errAck;
  assign codes[4] = sel.timer1;
  assign codes[5] = sel.timer2;
  assign codes[6] = sel.thermo;

  for (genvar g = 0; g < NSRC; g++) begin : gMux
    dlss_source_mux uMux (
      .code       (codes[g]),
      .board      (board),
      .mfiDigital (mfiDigital),
      .expHw      (expHw),
      .expEff     (expEff),
      .intl       (intl),
      .value      (srcVal[g])
    );
  end

  // Edges count only once the synchronisers and the previous-level register hold
  // real levels, so a source that rests high through reset gives no false edge.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      arm_q <= 3'h0;
    end else begin
      arm_q <= {arm_q[1:0], 1'b1}; // [R23]
    end
  end

  assign edgeArm = arm_q[2];

  // Previous selected levels for edge detection.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      src_q <= '0;
    end else begin
      src_q <= srcVal;
    end
  end

  assign cwNow = srcVal[0]; // [R13]
  assign acwNow = srcVal[1]; // [R13]
  assign enNow = srcVal[2];
  assign cwRise = cwNow & ~src_q[0] & edgeArm; // [R14]
  assign acwRise = acwNow & ~src_q[1] & edgeArm; // [R14]
  assign ackRise = srcVal[3] & ~src_q[3] & edgeArm; // [R20]
  assign threeWireMode = (localRemote == dlss_pkg::LOC_3WIRE) ||
                         (localRemote == dlss_pkg::LOC_3WIRE_KP); // [R19]
  assign enEff = threeWireMode & enNow;

  // Millisecond tick; it restarts with each latched start so the window is never short.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      tick_q <= '0;
    end else if (startNow || msTick) begin
      tick_q <= '0; // [R23]
    end else begin
      tick_q <= tick_q + 1'b1;
    end
  end

  assign msTick = (tick_q == dlss_pkg::TICK_W'(dlss_pkg::TICK_CYCLES - 1));

  // Three-wire start latch with plausibility window.
  assign bothRise = cwRise & acwRise; // [R18]
  assign startNow = enEff & ~latched_q & (cwRise | acwRise) & ~bothRise; // [R14] [R16]
  // During the window the held start must stay high and the other start low.
  assign pulseBad = dirCw_q ? (~cwNow | acwNow) : (~acwNow | cwNow); // [R17] [R18]
  assign abortNow = latched_q & (~enEff | (checking_q & pulseBad)); // [R15] [R17] [R18]
  assign stopNow = abortNow | (enEff & ~latched_q & bothRise); // [R15] [R18]
  assign windowEnd = msTick & (ms_q == dlss_pkg::MS_W'(dlss_pkg::PULSE_MIN_MS - 1)); // [R17]

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      latched_q <= 1'b0;
    end else if (startNow) begin
      latched_q <= 1'b1; // [R14] [R15]
    end else if (abortNow) begin
      latched_q <= 1'b0; // [R15]
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      dirCw_q <= 1'b0;
    end else if (startNow) begin
      dirCw_q <= cwRise;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      checking_q <= 1'b0;
    end else if (startNow) begin
      checking_q <= 1'b1;
    end else if (abortNow || windowEnd) begin
      checking_q <= 1'b0; // [R17]
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ms_q <= '0;
    end else if (startNow) begin
      ms_q <= '0;
    end else if (checking_q && msTick && !windowEnd) begin
      ms_q <= ms_q + 1'b1; // [R17]
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      stopReq <= 1'b0;
    end else begin
      stopReq <= stopNow; // [R15] [R17] [R18]
    end
  end

  // Drive command: three-wire latch or plain level start.
  always_comb begin
    if (threeWireMode) begin
      run_d = latched_q;
    end else begin
      run_d = cwNow ^ acwNow; // [R13]
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      runCw <= 1'b0;
      runAcw <= 1'b0;
    end else begin
      runCw <= run_d & (threeWireMode ? dirCw_q : cwNow); // [R13]
      runAcw <= run_d & (threeWireMode ? ~dirCw_q : acwNow); // [R13]
    end
  end

  // Fault latch: the fault event wins over an acknowledge in the same cycle.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      faultActive <= 1'b0;
    end else if (faultEvent) begin
      faultActive <= 1'b1;
    end else if (progAck || ackRise) begin
      faultActive <= 1'b0; // [R20]
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      errAckPulse <= 1'b0;
    end else begin
      errAckPulse <= progAck | ackRise; // [R20]
    end
  end

  // Trigger and mode for the first downstream timer.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      timer1Trig <= 1'b0;
      timer1ModeOut <= 4'h0;
    end else begin
      timer1Trig <= srcVal[4]; // [R21]
      timer1ModeOut <= timer1Mode; // [R21]
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      timer2Trig <= 1'b0;
      timer2ModeOut <= 4'h0;
    end else begin
      timer2Trig <= srcVal[5]; // [R21]
      timer2ModeOut <= timer2Mode; // [R21]
    end
  end

  // Thermo-contact level for the motor-temperature reaction.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      thermoLevel <= 1'b0;
    end else begin
      thermoLevel <= srcVal[6]; // [R22]
    end
  end

endmodule

`default_nettype wire

// ### verif/dlss_contacts.sv
`timescale 1ns/1ps
`default_nettype none

module dlss_contacts (
  // Requested contact levels: board[5:0], multifunction, expansion[2:0]
  input  wire logic [9:0]          want,
  // Pin levels seen by the drive
  output var  dlss_pkg::dlss_pins_t pins
);
  // Contacts are ideal switches held for whole cycles, so no bounce is modelled.
  assign pins = want;
endmodule

`default_nettype wire

// ### verif/dlss_top_asserts.sv
`timescale 1ns/1ps
`default_nettype none

module dlss_top_asserts (
  // Clock and reset
  input wire logic                     mclk,
  input wire logic                     nrst,
  // Inputs
  input wire dlss_pkg::dlss_internal_t intl,
  input wire dlss_pkg::dlss_sel_t      sel,
  input wire logic [5:0]               localRemote,
  input wire logic                     progAck,
  input wire logic                     faultEvent,
  input wire logic [3:0]               timer1Mode,
  // Outputs
  input wire logic                     runCw,
  input wire logic                     runAcw,
  input wire logic                     stopReq,
  input wire logic                     faultActive,
  input wire logic                     errAckPulse,
  input wire logic                     timer2Trig,
  input wire logic [3:0]               timer1ModeOut,
  input wire logic                     thermoLevel
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  a_stop_one_cycle: assert property (stopReq |=> !stopReq)
    else $error("stop request longer than one cycle");
  a_no_both_run: assert property (!(runCw && runAcw))
    else $error("both directions commanded");
  a_ack_from_prog: assert property (progAck |=> errAckPulse)
    else $error("programming acknowledge not passed on");
  a_fault_set_wins: assert property (faultEvent |=> faultActive)
    else $error("fault event did not set fault");
  a_timer_mode_pass: assert property (1'b1 |=> timer1ModeOut == $past(timer1Mode))
    else $error("timer mode not passed on");
  a_thermo_logic_three: assert property (
    sel.thermo == dlss_pkg::SRC_LOGIC3 |=> thermoLevel == $past(intl.logic3))
    else $error("thermo level not logic three");
  a_timer_inv_four: assert property (
    sel.timer2 == dlss_pkg::SRC_LOGIC4_INV |=> timer2Trig == !$past(intl.logic4))
    else $error("timer two not inverted logic four");
  a_level_mode_quiet: assert property (
    (localRemote != 6'h05 && localRemote != 6'h2E)[*3] |-> !stopReq)
    else $error("stop request outside three-wire mode");
  a_emerg_needs_bus: assert property (
    sel.thermo == dlss_pkg::SRC_EMERGENCY && !intl.sysbusFitted |=> !thermoLevel)
    else $error("emergency seen without system bus");
endmodule

bind dlss_top dlss_top_asserts u_chk (.mclk(mclk), .nrst(nrst), .intl(intl), .sel(sel),
  .localRemote(localRemote), .progAck(progAck), .faultEvent(faultEvent),
  .timer1Mode(timer1Mode), .runCw(runCw), .runAcw(runAcw), .stopReq(stopReq),
  .faultActive(faultActive), .errAckPulse(errAckPulse), .timer2Trig(timer2Trig),
  .timer1ModeOut(timer1ModeOut), .thermoLevel(thermoLevel));

`default_nettype wire

// ### verif/drive_logic_source_select_3wire_tb.sv
`timescale 1ns/1ps
`default_nettype none

module drive_logic_source_select_3wire_tb;
  logic                     mclk, nrst, progAck, faultEvent, s;
  logic                     runCw, runAcw, stopReq, faultActive, errAckPulse;
  logic                     timer1Trig, timer2Trig, thermoLevel;
  logic [9:0]               want;
  logic [2:0]               mfiMode;
  logic [5:0]               localRemote;
  logic [3:0]               timer1Mode, timer2Mode, timer1ModeOut, timer2ModeOut;
  logic [15:0]              lfsr = 16'h9E37;
  logic [31:0]              rv;
  dlss_pkg::dlss_pins_t     pins;
  dlss_pkg::dlss_internal_t intl;
  dlss_pkg::dlss_sel_t      sel;
  int                       miscompares = 0;
  int                       n_tests = 0;

  dlss_contacts u_contacts (.want(want), .pins(pins));
  dlss_top dut (.mclk(mclk), .nrst(nrst), .pins(pins), .intl(intl), .sel(sel),
    .mfiMode(mfiMode), .localRemote(localRemote), .progAck(progAck), .faultEvent(faultEvent),
    .timer1Mode(timer1Mode), .timer2Mode(timer2Mode), .runCw(runCw), .runAcw(runAcw),
    .stopReq(stopReq), .faultActive(faultActive), .errAckPulse(errAckPulse),
    .timer1Trig(timer1Trig), .timer2Trig(timer2Trig), .timer1ModeOut(timer1ModeOut),
    .timer2ModeOut(timer2ModeOut), .thermoLevel(thermoLevel));

  function automatic logic [15:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr;
  endfunction

  // Reference selection built from integer code ranges.
  function automatic logic src(input int k);
    if (k >= 70 && k <= 76) return intl.base[k-70];
    if (k == 224 || k == 225) return intl.logic3 ^ (k == 225);
    if (k == 226 || k == 227) return intl.logic4 ^ (k == 227);
    if (k >= 270 && k <= 276) return !src(k - 200);
    if (k == 282) return intl.posReached;
    if (k >= 320 && k <= 322) begin
      return intl.expRemoteSel[k-320] ? intl.expRemote[k-320] : pins.expansion[k-320];
    end
    if (k >= 520 && k <= 522) return !src(k - 200);
    if (k >= 525 && k <= 530) return pins.board[k-525];
    if (k == 531) return (mfiMode == 3'h3) && pins.mfi;
    if (k >= 532 && k <= 534) return pins.expansion[k-532];
    if (k >= 537 && k <= 545) return !src(k - 12);
    if (k >= 700 && k <= 703) return intl.sysbusFitted && intl.pdo1[k-700];
    if (k >= 710 && k <= 713) return intl.sysbusFitted && intl.pdo2[k-710];
    if (k >= 720 && k <= 723) return intl.sysbusFitted && intl.pdo3[k-720];
    if (k == 730) return intl.sysbusFitted && intl.emergency;
    return 1'b0;
  endfunction

  task automatic check(input string nm, input logic [3:0] exp, input logic [3:0] got);
    n_tests++;
    if (got !== exp) begin
      $display("BAD %s expected %h seen %h", nm, exp, got);
      miscompares++;
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(negedge mclk);
  endtask

  task automatic see_stop(output logic seen);
    seen = 1'b0;
    repeat (4) begin
      @(posedge mclk);
      #1;
      if (stopReq === 1'b1) seen = 1'b1;
    end
    step(1);
  endtask

  task automatic three_wire(input logic [5:0] m);
    localRemote = m;
    intl.base = 7'h01;
    step(2);
    intl.base = 7'h03;
    step(3);
    check("runCw", 4'h1, 4'(runCw));
    step(2000);
    intl.base = 7'h01;
    see_stop(s);
    check("shortPulseStop", 4'h2, {2'h0, s, runCw});
    intl.base = 7'h05;
    step(3);
    check("runAcw", 4'h1, 4'(runAcw));
    step(100);
    intl.base = 7'h07;
    see_stop(s);
    check("bothStartStop", 4'h2, {2'h0, s, runAcw});
    intl.base = 7'h01;
    step(3);
    intl.base = 7'h03;
    step(3);
    intl.base = 7'h02;
    see_stop(s);
    check("enableOffStop", 4'h2, {2'h0, s, runCw});
    intl.base = 7'h00;
    step(2);
    intl.base = 7'h02;
    step(3);
    check("runCwNoEnable", 4'h0, 4'(runCw));
    intl.base = 7'h00;
    step(2);
  endtask

  task automatic complete_run();
    if (miscompares == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  initial begin
    #1500000;
    miscompares++;
    complete_run();
  end

  initial begin
    {nrst, progAck, faultEvent, want, intl, sel} = '0;
    {mfiMode, localRemote, timer1Mode, timer2Mode} = '0;
    step(10);
    nrst = 1'b1;
    for (int c = 0; c < 1024; c++) begin
      rv = {rnd(), rnd()};
      intl = rv[29:0];
      want = rv[31:22];
      rv = {rnd(), rnd()};
      {timer2Mode, timer1Mode, localRemote, mfiMode} = rv[16:0];
      sel.thermo = 10'(c);
      sel.timer1 = 10'(c);
      sel.timer2 = 10'(c);
      step(4);
      check("thermoLevel", 4'(src(c)), 4'(thermoLevel));
      check("timer1Trig", 4'(src(c)), 4'(timer1Trig));
      check("timer2Trig", 4'(src(c)), 4'(timer2Trig));
      check("timer1ModeOut", timer1Mode, timer1ModeOut);
      check("timer2ModeOut", timer2Mode, timer2ModeOut);
    end
    intl = '0;
    sel = '0;
    sel.threeWire = 10'h046;
    sel.startCw = 10'h047;
    sel.startAcw = 10'h048;
    sel.errAck = 10'h049;
    step(3);
    three_wire(6'h05);
    three_wire(6'h2E);
    localRemote = 6'h00;
    intl.base = 7'h03;
    step(3);
    check("levelRunCw", 4'h1, 4'(runCw));
    intl.base = 7'h07;
    step(3);
    check("levelBoth", 4'h0, {2'h0, runCw, runAcw});
    intl.base = 7'h00;
    faultEvent = 1'b1;
    step(1);
    faultEvent = 1'b0;
    step(2);
    check("faultActive", 4'h1, 4'(faultActive));
    progAck = 1'b1;
    step(1);
    progAck = 1'b0;
    check("errAckPulse", 4'h1, 4'(errAckPulse));
    step(2);
    check("faultProgClear", 4'h0, 4'(faultActive));
    faultEvent = 1'b1;
    step(1);
    faultEvent = 1'b0;
    step(2);
    intl.base = 7'h08;
    step(3);
    check("faultSrcClear", 4'h0, 4'(faultActive));
    intl.base = 7'h00;
    faultEvent = 1'b1;
    progAck = 1'b1;
    step(1);
    faultEvent = 1'b0;
    progAck = 1'b0;
    step(2);
    check("faultSetWins", 4'h1, 4'(faultActive));
    complete_run();
  end
endmodule

`default_nettype wire
